// File: dfr_pkg.sv
// Shared constants for the dual FIFO reset and configuration control
package dfr_pkg;
  // Reset and flag timing, in port clock rising edges
  localparam int RESET_EDGES = 4;
  localparam int IR_DELAY_EDGES = 2;
  // Clock figures
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int PORT_CLK_PERIOD_NS = 80;
  localparam int PORT_CLK_HALF_CYC =
    PORT_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  // One spare port period so the far end surely sees four edges
  localparam int RESET_HOLD_CYC =
    (RESET_EDGES + 1) * PORT_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  // Offset registers
  localparam int OFS_W = 10;
  localparam logic [OFS_W-1:0] OFS_PRESET_HI = 10'h040;
  localparam logic [OFS_W-1:0] OFS_PRESET_MID = 10'h010;
  localparam logic [OFS_W-1:0] OFS_PRESET_LO = 10'h008;
  localparam logic [OFS_W-1:0] OFS_CLEAR = 10'h000;
  // Controller register map (byte addresses)
  localparam int AVS_ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // CTRL bits 0-3: request a reset pulse; bit 4 reads busy
  localparam int CTRL_MST1 = 0;
  localparam int CTRL_MST2 = 1;
  localparam int CTRL_PRT1 = 2;
  localparam int CTRL_PRT2 = 3;
  localparam int CTRL_BUSY = 4;
  // CFG bits: pin levels
  localparam int CFG_W = 7;
  localparam int CFG_BEF = 0;
  localparam int CFG_FS0 = 1;
  localparam int CFG_FS1 = 2;
  localparam int CFG_SPM = 3;
  localparam int CFG_MBA = 4;
  localparam int CFG_MBB = 5;
  localparam int CFG_MBC = 6;
  localparam logic [CFG_W-1:0] CFG_RST = 7'h4F;
  // STATUS: device flags in bits 9..0, busy in bit 10
  localparam int STAT_FLAGS = 10;
  localparam int STAT_BUSY = 10;
endpackage

// File: dfr_if.sv
// Pin bundle between the FIFO device and its reset controller
`timescale 1ns/1ns
interface dfr_if;
  // Clocks and resets, made by the controller
  logic wide_port_clock;
  logic transmit_port_clock;
  logic receive_port_clock;
  logic fifo1_master_reset_n;
  logic fifo2_master_reset_n;
  logic fifo1_partial_reset_n;
  logic fifo2_partial_reset_n;
  // Configuration and mailbox selects
  logic endian_or_timing_select;
  logic flag_select0_serial_data;
  logic flag_select1_serial_enable;
  logic serial_program_mode_n;
  logic wide_port_mailbox_select;
  logic transmit_port_mailbox_select;
  logic receive_port_mailbox_select;
  // Flags, made by the device
  logic wide_side_full_or_input_ready;
  logic receive_side_full_or_input_ready;
  logic wide_side_empty_or_output_ready;
  logic transmit_side_empty_or_output_ready;
  logic wide_side_almost_empty_n;
  logic transmit_side_almost_empty_n;
  logic wide_side_almost_full_n;
  logic receive_side_almost_full_n;
  logic mailbox1_full_n;
  logic mailbox2_full_n;

  modport dev (
    input wide_port_clock, transmit_port_clock, receive_port_clock,
    input fifo1_master_reset_n, fifo2_master_reset_n,
    input fifo1_partial_reset_n, fifo2_partial_reset_n,
    input endian_or_timing_select, flag_select0_serial_data,
    input flag_select1_serial_enable, serial_program_mode_n,
    input wide_port_mailbox_select, transmit_port_mailbox_select,
    input receive_port_mailbox_select,
    output wide_side_full_or_input_ready, receive_side_full_or_input_ready,
    output wide_side_empty_or_output_ready,
    output transmit_side_empty_or_output_ready,
    output wide_side_almost_empty_n, transmit_side_almost_empty_n,
    output wide_side_almost_full_n, receive_side_almost_full_n,
    output mailbox1_full_n, mailbox2_full_n
  );

  modport ctl (
    output wide_port_clock, transmit_port_clock, receive_port_clock,
    output fifo1_master_reset_n, fifo2_master_reset_n,
    output fifo1_partial_reset_n, fifo2_partial_reset_n,
    output endian_or_timing_select, flag_select0_serial_data,
    output flag_select1_serial_enable, serial_program_mode_n,
    output wide_port_mailbox_select, transmit_port_mailbox_select,
    output receive_port_mailbox_select,
    input wide_side_full_or_input_ready, receive_side_full_or_input_ready,
    input wide_side_empty_or_output_ready,
    input transmit_side_empty_or_output_ready,
    input wide_side_almost_empty_n, transmit_side_almost_empty_n,
    input wide_side_almost_full_n, receive_side_almost_full_n,
    input mailbox1_full_n, mailbox2_full_n
  );
endinterface

// File: dfr_device.sv
// Device end: reset, flag and configuration control of two FIFOs
//
// How it works
// - Controller pulses both master resets after power-up
// - FIFO1 master reset spans four edges each
// - FIFO2 master reset spans four edges each
// - Reset inputs are synchronised inside the device
// - Master reset clears pointers, sets flag levels
// - Master reset sets mailbox flag high
// - Input ready rises two write edges later
// - FIFO1 master release latches endian and programming
// - FIFO2 master release alone clears its offsets
// - Receive mailbox select high until ready
// - FIFO1 partial reset spans four edges each
// - FIFO2 partial reset spans four edges each
// - Partial reset acts like master on flags
// - Partial reset keeps offsets, method and mode
// - Endian high: most significant part first
// - Endian low: least significant part first
// - Pin high at next edge: standard mode
// - Pin low at next edge: fall-through mode
// - Standard mode: empty/full flags, explicit reads
// - Fall-through: ready flags, first word appears
// - Controller keeps endian/timing pin static
// - Four offset registers, preset or programmed
// - Flag selects pick 64, 16, 8 or parallel
`timescale 1ns/1ns
module dfr_device
  import dfr_pkg::*;
#(
  parameter int OW = OFS_W
) (
  // System
  input wire logic sys_clk,
  input wire logic nrst,
  // Link
  dfr_if.dev link,
  // FIFO core flags, index 0 is FIFO1, 1 is FIFO2
  input wire logic [1:0] core_not_full,
  input wire logic [1:0] core_not_empty,
  input wire logic [1:0] core_almost_empty_n,
  input wire logic [1:0] core_almost_full_n,
  input wire logic [1:0] core_mailbox_full_n,
  // FIFO core control
  output logic [1:0] fifo_clear,
  output logic [1:0] fall_through_mode,
  output logic big_endian,
  output logic parallel_load,
  output logic serial_load,
  // Offset registers
  output logic [OW-1:0] fifo1_empty_offset,
  output logic [OW-1:0] fifo1_full_offset,
  output logic [OW-1:0] fifo2_empty_offset,
  output logic [OW-1:0] fifo2_full_offset
);

  localparam int NPIN = 11;
  localparam logic [1:0] IR_LAST = 2'(IR_DELAY_EDGES - 1);

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic [NPIN-1:0] pin_prev_reg;
  logic [1:0] ir_cnt_reg [2];
  logic [1:0] ir_ready_reg;
  logic [1:0] mode_wait_reg;
  logic [1:0] ft_reg;
  logic [1:0] clear_reg;
  logic [1:0] ir_out_reg;
  logic [1:0] ne_out_reg;
  logic [1:0] ae_out_reg;
  logic [1:0] af_out_reg;
  logic [1:0] mbf_out_reg;
  logic be_reg;
  logic par_reg;
  logic ser_reg;
  logic [OW-1:0] x1_reg;
  logic [OW-1:0] y1_reg;
  logic [OW-1:0] x2_reg;
  logic [OW-1:0] y2_reg;

  // Pin order: 0 endian/timing, 1-3 flag selects and mode,
  // 4-6 port clocks, 7-8 master resets, 9-10 partial resets
  assign pin_raw = {
    link.fifo2_partial_reset_n,
    link.fifo1_partial_reset_n,
    link.fifo2_master_reset_n,
    link.fifo1_master_reset_n,
    link.receive_port_clock,
    link.transmit_port_clock,
    link.wide_port_clock,
    link.serial_program_mode_n,
    link.flag_select1_serial_enable,
    link.flag_select0_serial_data,
    link.endian_or_timing_select
  };

  wire bef_lvl = pin_sync_reg[0];
  wire [1:0] fs_lvl = pin_sync_reg[2:1];
  wire spm_lvl = pin_sync_reg[3];
  wire [1:0] mst_n = pin_sync_reg[8:7];
  wire [1:0] prt_n = pin_sync_reg[10:9];
  wire [1:0] mst_rise = mst_n & ~pin_prev_reg[8:7];
  // Write clock of FIFO1 is the wide port, of FIFO2 the receive port
  wire [1:0] wclk_rise = {pin_sync_reg[6] & ~pin_prev_reg[6],
                          pin_sync_reg[4] & ~pin_prev_reg[4]};
  wire [1:0] in_rst = ~(mst_n & prt_n);
  wire use_preset = spm_lvl & (fs_lvl != 2'b00);
  wire par_sel = spm_lvl & (fs_lvl == 2'b00);
  wire ser_sel = ~spm_lvl & (fs_lvl == 2'b10);
  wire [OW-1:0] preset_val =
    (fs_lvl == 2'b11) ? OW'(OFS_PRESET_HI) :
    (fs_lvl == 2'b10) ? OW'(OFS_PRESET_MID) :
    OW'(OFS_PRESET_LO);
  wire [OW-1:0] ofs1_next = use_preset ? preset_val : OW'(OFS_CLEAR);
  // FIFO2 takes the preset only when both masters rise together
  wire [OW-1:0] ofs2_next = (use_preset & mst_rise[0]) ?
    preset_val : OW'(OFS_CLEAR);

  // Two-stage synchroniser, edges taken from the second stage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Input-ready delay and timing mode per FIFO
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2; i++) begin
        ir_cnt_reg[i] <= '0;
      end
      ir_ready_reg <= '0;
      mode_wait_reg <= '0;
      ft_reg <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (in_rst[i]) begin
          ir_cnt_reg[i] <= '0;
          ir_ready_reg[i] <= 1'b0;
        end else if (wclk_rise[i] && !ir_ready_reg[i]) begin
          ir_cnt_reg[i] <= ir_cnt_reg[i] + 2'd1;
          if (ir_cnt_reg[i] == IR_LAST) begin
            ir_ready_reg[i] <= 1'b1;
          end
        end
        // Partial reset never touches the mode
        if (mst_rise[i]) begin
          mode_wait_reg[i] <= 1'b1;
        end else if (mode_wait_reg[i] && wclk_rise[i]) begin
          mode_wait_reg[i] <= 1'b0;
          ft_reg[i] <= ~bef_lvl;
        end
      end
    end
  end

  // Flag outputs forced to reset levels while a reset is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clear_reg <= 2'b11;
      ir_out_reg <= '0;
      ne_out_reg <= '0;
      ae_out_reg <= '0;
      af_out_reg <= 2'b11;
      mbf_out_reg <= 2'b11;
    end else begin
      clear_reg <= in_rst;
      ir_out_reg <= ~in_rst & ir_ready_reg & core_not_full;
      ne_out_reg <= ~in_rst & core_not_empty;
      ae_out_reg <= ~in_rst & core_almost_empty_n;
      af_out_reg <= in_rst | core_almost_full_n;
      mbf_out_reg <= in_rst | core_mailbox_full_n;
    end
  end

  // Configuration and offsets, changed by master releases only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      be_reg <= 1'b0;
      par_reg <= 1'b0;
      ser_reg <= 1'b0;
      x1_reg <= OW'(OFS_CLEAR);
      y1_reg <= OW'(OFS_CLEAR);
      x2_reg <= OW'(OFS_CLEAR);
      y2_reg <= OW'(OFS_CLEAR);
    end else begin
      if (mst_rise[0]) begin
        be_reg <= bef_lvl;
        par_reg <= par_sel;
        ser_reg <= ser_sel;
        x1_reg <= ofs1_next;
        y1_reg <= ofs1_next;
      end
      if (mst_rise[1]) begin
        x2_reg <= ofs2_next;
        y2_reg <= ofs2_next;
      end
    end
  end

  assign fifo_clear = clear_reg;
  assign fall_through_mode = ft_reg;
  assign big_endian = be_reg;
  assign parallel_load = par_reg;
  assign serial_load = ser_reg;
  assign fifo1_empty_offset = x1_reg;
  assign fifo1_full_offset = y1_reg;
  assign fifo2_empty_offset = x2_reg;
  assign fifo2_full_offset = y2_reg;

  // FIFO1 flags
  assign link.wide_side_full_or_input_ready = ir_out_reg[0];
  assign link.transmit_side_empty_or_output_ready = ne_out_reg[0];
  assign link.transmit_side_almost_empty_n = ae_out_reg[0];
  assign link.wide_side_almost_full_n = af_out_reg[0];
  assign link.mailbox1_full_n = mbf_out_reg[0];
  // FIFO2 flags
  assign link.receive_side_full_or_input_ready = ir_out_reg[1];
  assign link.wide_side_empty_or_output_ready = ne_out_reg[1];
  assign link.wide_side_almost_empty_n = ae_out_reg[1];
  assign link.receive_side_almost_full_n = af_out_reg[1];
  assign link.mailbox2_full_n = mbf_out_reg[1];

endmodule

// File: dfr_ctl.sv
// Controller end: makes port clocks, reset pulses and pin levels
`timescale 1ns/1ns
module dfr_ctl
  import dfr_pkg::*;
(
  // System
  input wire logic sys_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link
  dfr_if.ctl link
);

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_MBWAIT} dfr_state_t;

  localparam int DIV_W = $clog2(PORT_CLK_HALF_CYC);
  localparam int HOLD_W = $clog2(RESET_HOLD_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PORT_CLK_HALF_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYC - 1);

  dfr_state_t state_reg;
  dfr_state_t state_next;
  logic [DIV_W-1:0] div_reg;
  logic port_clk_reg;
  logic [HOLD_W-1:0] hold_reg;
  logic [3:0] kind_reg;
  logic [3:0] kind_next;
  logic [3:0] rst_n_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic bef_reg;
  logic mbc_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [STAT_FLAGS-1:0] flag_meta_reg;
  logic [STAT_FLAGS-1:0] flag_sync_reg;

  wire [STAT_FLAGS-1:0] flag_raw = {
    link.mailbox2_full_n, link.mailbox1_full_n,
    link.receive_side_almost_full_n, link.wide_side_almost_full_n,
    link.transmit_side_almost_empty_n, link.wide_side_almost_empty_n,
    link.transmit_side_empty_or_output_ready,
    link.wide_side_empty_or_output_ready,
    link.receive_side_full_or_input_ready,
    link.wide_side_full_or_input_ready
  };
  wire both_ready = flag_sync_reg[0] & flag_sync_reg[1];
  wire busy = (state_reg != ST_IDLE);
  wire req = avs_read | avs_write;
  wire take_wr = avs_write & ~wait_reg;
  wire ctrl_wr = take_wr & (avs_address == REG_CTRL);
  wire cfg_wr = take_wr & (avs_address == REG_CFG);
  wire start = ctrl_wr & ~busy & (avs_writedata[3:0] != 4'h0);
  wire hold_done = (state_reg == ST_HOLD) & (hold_reg == HOLD_LAST);
  wire master_kind = kind_reg[CTRL_MST1] | kind_reg[CTRL_MST2];
  wire mst_start =
    start & (avs_writedata[CTRL_MST1] | avs_writedata[CTRL_MST2]);
  // High from the very edge a master pulse starts until idle again
  wire mbc_hold = (state_next != ST_IDLE) &
    (kind_next[CTRL_MST1] | kind_next[CTRL_MST2]);
  wire [31:0] rd_mux =
    (avs_address == REG_CTRL) ? {27'h0, busy, kind_reg} :
    (avs_address == REG_CFG) ? {25'h0, cfg_reg} :
    (avs_address == REG_STATUS) ? {21'h0, busy, flag_sync_reg} :
    32'h0;

  // Pulse sequencer
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_HOLD;
          kind_next = avs_writedata[3:0];
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          state_next = master_kind ? ST_MBWAIT : ST_IDLE;
        end
      end
      ST_MBWAIT: begin
        if (both_ready) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_HOLD;
      kind_reg <= 4'h3;
      hold_reg <= '0;
      rst_n_reg <= 4'hC;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      hold_reg <= (state_reg == ST_HOLD) ? hold_reg + 1'b1 : '0;
      if (state_next == ST_HOLD) begin
        rst_n_reg <= ~kind_next;
      end else begin
        rst_n_reg <= 4'hF;
      end
    end
  end

  // Free-running port clock from a divider
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= '0;
      port_clk_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
      if (div_reg == DIV_LAST) begin
        port_clk_reg <= ~port_clk_reg;
      end
    end
  end

  // Pin levels; endian/timing level moves only as a master starts
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= CFG_RST;
      bef_reg <= CFG_RST[CFG_BEF];
      mbc_reg <= 1'b1;
    end else begin
      if (cfg_wr) begin
        cfg_reg <= avs_writedata[CFG_W-1:0];
      end
      if (mst_start) begin
        bef_reg <= cfg_reg[CFG_BEF];
      end
      mbc_reg <= mbc_hold | cfg_reg[CFG_MBC];
    end
  end

  // Device flags are asynchronous here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_meta_reg <= '0;
      flag_sync_reg <= '0;
    end else begin
      flag_meta_reg <= flag_raw;
      flag_sync_reg <= flag_meta_reg;
    end
  end

  // Bus answer one cycle after a request is seen
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (avs_read && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign link.wide_port_clock = port_clk_reg;
  assign link.transmit_port_clock = port_clk_reg;
  assign link.receive_port_clock = port_clk_reg;
  assign link.fifo1_master_reset_n = rst_n_reg[CTRL_MST1];
  assign link.fifo2_master_reset_n = rst_n_reg[CTRL_MST2];
  assign link.fifo1_partial_reset_n = rst_n_reg[CTRL_PRT1];
  assign link.fifo2_partial_reset_n = rst_n_reg[CTRL_PRT2];
  assign link.endian_or_timing_select = bef_reg;
  assign link.flag_select0_serial_data = cfg_reg[CFG_FS0];
  assign link.flag_select1_serial_enable = cfg_reg[CFG_FS1];
  assign link.serial_program_mode_n = cfg_reg[CFG_SPM];
  assign link.wide_port_mailbox_select = cfg_reg[CFG_MBA];
  assign link.transmit_port_mailbox_select = cfg_reg[CFG_MBB];
  assign link.receive_port_mailbox_select = mbc_reg;

endmodule

// File: dfr_monitor.sv
// Checker on the pins between the FIFO device and its reset controller
`timescale 1ns/1ns
module dfr_monitor (
  // System
  input wire logic sys_clk,
  input wire logic nrst,
  // Resets and selects
  input wire logic fifo1_master_reset_n,
  input wire logic fifo2_master_reset_n,
  input wire logic fifo1_partial_reset_n,
  input wire logic fifo2_partial_reset_n,
  input wire logic receive_port_mailbox_select,
  // Device flags
  input wire logic wide_side_full_or_input_ready,
  input wire logic receive_side_full_or_input_ready,
  input wire logic wide_side_empty_or_output_ready,
  input wire logic transmit_side_empty_or_output_ready,
  input wire logic wide_side_almost_empty_n,
  input wire logic transmit_side_almost_empty_n,
  input wire logic wide_side_almost_full_n,
  input wire logic receive_side_almost_full_n,
  input wire logic mailbox1_full_n,
  input wire logic mailbox2_full_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire run1 = fifo1_master_reset_n && fifo1_partial_reset_n;
  wire run2 = fifo2_master_reset_n && fifo2_partial_reset_n;
  logic [5:0] hi1_reg, hi2_reg, lo1_reg, lo2_reg;
  // Saturating cycle counts since release and while in reset
  wire [5:0] hi1_next = run1 ? hi1_reg + {5'h00, hi1_reg != 6'h3F} : 6'h00;
  wire [5:0] hi2_next = run2 ? hi2_reg + {5'h00, hi2_reg != 6'h3F} : 6'h00;
  wire [5:0] lo1_next = run1 ? 6'h00 : lo1_reg + {5'h00, lo1_reg != 6'h3F};
  wire [5:0] lo2_next = run2 ? 6'h00 : lo2_reg + {5'h00, lo2_reg != 6'h3F};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {hi1_reg, hi2_reg, lo1_reg, lo2_reg} <= 24'h000000;
    end else begin
      {hi1_reg, hi2_reg, lo1_reg, lo2_reg} <=
        {hi1_next, hi2_next, lo1_next, lo2_next};
    end
  end
  a_fifo1_mst_flags: assert property (
    !fifo1_master_reset_n [*6] |-> !wide_side_full_or_input_ready &&
    !transmit_side_empty_or_output_ready && !transmit_side_almost_empty_n &&
    wide_side_almost_full_n && mailbox1_full_n)
    else $error("fifo1 flags off reset level");
  a_fifo2_mst_flags: assert property (
    !fifo2_master_reset_n [*6] |-> !receive_side_full_or_input_ready &&
    !wide_side_empty_or_output_ready && !wide_side_almost_empty_n &&
    receive_side_almost_full_n && mailbox2_full_n)
    else $error("fifo2 flags off reset level");
  a_fifo1_part_flags: assert property (
    $fell(fifo1_partial_reset_n) ##5 !fifo1_partial_reset_n |->
    !wide_side_full_or_input_ready && !transmit_side_almost_empty_n &&
    wide_side_almost_full_n && mailbox1_full_n)
    else $error("fifo1 partial flags wrong");
  a_fifo2_part_flags: assert property (
    !fifo2_partial_reset_n [*6] |-> !receive_side_full_or_input_ready &&
    !wide_side_empty_or_output_ready && mailbox2_full_n)
    else $error("fifo2 partial flags wrong");
  a_ir1_window: assert property (
    $rose(wide_side_full_or_input_ready) |->
    hi1_reg >= 6'h09 && hi1_reg <= 6'h1C)
    else $error("wide ready rose at wrong time");
  a_ir2_window: assert property (
    $rose(receive_side_full_or_input_ready) |->
    hi2_reg >= 6'h09 && hi2_reg <= 6'h1C)
    else $error("receive ready rose at wrong time");
  a_mbc_held_high: assert property (
    (!fifo1_master_reset_n || !fifo2_master_reset_n) |->
    receive_port_mailbox_select)
    else $error("receive mailbox select low in reset");
  a_span1_long: assert property (
    $rose(run1) |-> lo1_reg >= 6'h20)
    else $error("fifo1 reset pulse too short");
  a_span2_long: assert property (
    $rose(run2) |-> lo2_reg >= 6'h20)
    else $error("fifo2 reset pulse too short");
endmodule

// File: test_dual_fifo_reset_config_control.sv
// Testbench joining controller and device ends over the pin bundle
`timescale 1ns/1ns
module test_dual_fifo_reset_config_control;
  import dfr_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, big_endian, parallel_load, serial_load;
  logic [1:0] fifo_clear, fall_through_mode;
  logic [OFS_W-1:0] ofs [4];
  logic [44:0] dev_state;
  int err_total = 0;
  int tests_run = 0;
  logic [2:0] mb_pins;
  logic [6:0] cfg_tab [5] = '{7'h38, 7'h44, 7'h4D, 7'h4F, 7'h4A};
  logic [44:0] exp_dev [5] = '{{1'b0, 2'b11, 2'b10, 40'h0},
    {1'b0, 2'b11, 2'b01, 40'h0}, {1'b1, 2'b00, 2'b00, {4{OFS_PRESET_MID}}},
    {1'b1, 2'b00, 2'b00, {4{OFS_PRESET_HI}}},
    {1'b0, 2'b11, 2'b00, {4{OFS_PRESET_LO}}}};
  assign dev_state = {big_endian, fall_through_mode, parallel_load,
    serial_load, ofs[0], ofs[1], ofs[2], ofs[3]};
  dfr_if i_dfr_if ();
  dfr_ctl i_dfr_ctl (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(i_dfr_if.ctl));
  dfr_device i_dfr_device (.sys_clk(sys_clk), .nrst(nrst),
    .link(i_dfr_if.dev), .core_not_full(2'b11), .core_not_empty(2'b11),
    .core_almost_empty_n(2'b11), .core_almost_full_n(2'b00),
    .core_mailbox_full_n(2'b00), .fifo_clear(fifo_clear),
    .fall_through_mode(fall_through_mode), .big_endian(big_endian),
    .parallel_load(parallel_load), .serial_load(serial_load),
    .fifo1_empty_offset(ofs[0]), .fifo1_full_offset(ofs[1]),
    .fifo2_empty_offset(ofs[2]), .fifo2_full_offset(ofs[3]));
  dfr_monitor i_dfr_monitor (.sys_clk(sys_clk), .nrst(nrst),
    .fifo1_master_reset_n(i_dfr_if.fifo1_master_reset_n),
    .fifo2_master_reset_n(i_dfr_if.fifo2_master_reset_n),
    .fifo1_partial_reset_n(i_dfr_if.fifo1_partial_reset_n),
    .fifo2_partial_reset_n(i_dfr_if.fifo2_partial_reset_n),
    .receive_port_mailbox_select(i_dfr_if.receive_port_mailbox_select),
    .wide_side_full_or_input_ready(i_dfr_if.wide_side_full_or_input_ready),
    .receive_side_full_or_input_ready(
      i_dfr_if.receive_side_full_or_input_ready),
    .wide_side_empty_or_output_ready(
      i_dfr_if.wide_side_empty_or_output_ready),
    .transmit_side_empty_or_output_ready(
      i_dfr_if.transmit_side_empty_or_output_ready),
    .wide_side_almost_empty_n(i_dfr_if.wide_side_almost_empty_n),
    .transmit_side_almost_empty_n(i_dfr_if.transmit_side_almost_empty_n),
    .wide_side_almost_full_n(i_dfr_if.wide_side_almost_full_n),
    .receive_side_almost_full_n(i_dfr_if.receive_side_almost_full_n),
    .mailbox1_full_n(i_dfr_if.mailbox1_full_n),
    .mailbox2_full_n(i_dfr_if.mailbox2_full_n));
  assign mb_pins = {i_dfr_if.receive_port_mailbox_select,
    i_dfr_if.transmit_port_mailbox_select,
    i_dfr_if.wide_port_mailbox_select};
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    $display("wrong value at %0t: no answer", $time);
    test_done();
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      hang();
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: reg %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_dev(input logic [44:0] got, input logic [44:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: device %h not %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk_reg(rd, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(REG_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 100);
    if (rd[STAT_BUSY] !== 1'b0) begin
      hang();
    end
    repeat (30) @(posedge sys_clk);
  endtask
  // Reset pulse: flags looked at mid-pulse, then wait until settled
  task automatic pulse(input logic [31:0] kind, input logic [31:0] stat,
      input logic [1:0] clr);
    bus(REG_CTRL, 1'b1, kind);
    repeat (15) @(posedge sys_clk);
    rd_chk(REG_STATUS, stat);
    chk_dev({43'h0, fifo_clear}, {43'h0, clr});
    wait_idle();
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    wait_idle();
    rd_chk(REG_STATUS, 32'h03F);
    rd_chk(REG_CFG, {25'h0, CFG_RST});
    rd_chk(4'hC, 32'h0);
    chk_dev(dev_state, exp_dev[3]);
    for (int i = 0; i < 5; i++) begin
      bus(REG_CFG, 1'b1, {25'h0, cfg_tab[i]});
      pulse(32'h3, 32'h7C0, 2'b11);
      chk_dev(dev_state, exp_dev[i]);
      rd_chk(REG_STATUS, 32'h03F);
      chk_dev({42'h0, mb_pins}, {42'h0, cfg_tab[i][CFG_MBC:CFG_MBA]});
    end
    bus(REG_CFG, 1'b1, 32'h4F);
    pulse(32'h4, 32'h556, 2'b01);
    pulse(32'h8, 32'h6A9, 2'b10);
    chk_dev(dev_state, exp_dev[4]);
    rd_chk(REG_STATUS, 32'h03F);
    pulse(32'h2, 32'h6A9, 2'b10);
    chk_dev(dev_state, {3'b001, 2'b00, {2{OFS_PRESET_LO}}, 20'h0});
    test_done();
  end
endmodule
